// File: core/mrs_slave_functions.sv
// Query interpreter for coil writes and holding register read, preset and multi-preset
`default_nettype none
// How it works
// RQ1: Function 0F sets each coil in range from the matching force data bit.
// RQ2: Broadcast coil writes execute exactly like addressed ones, without reply.
// RQ3: Coil addresses are zero-based; coil number equals address plus one.
// RQ4: Coils 17 to 32 form the 16-bit speed setpoint reference.
// RQ5: Coil write reply carries address, function, start and quantity, then CRC.
// RQ6: Function 03 returns the holding registers from start for quantity.
// RQ7: Function 03 register addresses are zero-based.
// RQ8: Each read register goes out high byte first, then low byte.
// RQ9: Function 06 writes the 16-bit value into the addressed register.
// RQ10: Preset register addresses are zero-based.
// RQ11: Single preset reply is an exact echo, sent after the write.
// RQ12: Function 10 writes consecutive registers from start for the count.
// RQ13: Multi preset reply carries address, function, start and quantity, then CRC.
// RQ14: 32-bit values use two registers, high word at lower address.
// RQ15: The master sends fractional values as scaled integers.
// RQ16: Broadcast reads are neither executed nor answered.
// RQ17: Read reply byte count is twice the register quantity.
// RQ18: Frames with bad CRC are dropped silently; replies carry a CRC.
module mrs_slave_functions
    import mrs_pkg::*;
#(
    parameter int REG_COUNT  = 16,
    parameter int COIL_COUNT = 64,
    parameter int MAX_FRAME  = 32
) (
    input  wire logic                    core_clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic [7:0]              slave_addr_in,
    input  wire logic [7:0]              rx_byte_in,
    input  wire logic                    rx_valid_in,
    input  wire logic                    rx_frame_end_in,
    output logic                         rx_idle_out,
    output logic [7:0]                   tx_byte_out,
    output logic                         tx_valid_out,
    output logic                         tx_last_out,
    input  wire logic                    tx_ready_in,
    output logic [COIL_COUNT-1:0]        coils_out,
    output logic [15:0]                  speed_ref_out,
    output logic [REG_COUNT*16-1:0]      hold_regs_out
);
    localparam int LW = $clog2(MAX_FRAME + 1);
    localparam int BW = $clog2(MAX_FRAME);
    localparam int RW = $clog2(REG_COUNT);

    mrs_state_type   state_q;
    logic [7:0]      rx_buf_q [MAX_FRAME];
    logic [LW-1:0]   rx_len_q;
    logic            overflow_q;
    logic [7:0]      tx_idx_q;
    logic [7:0]      tx_byte_q;
    logic [15:0]     regs_q [REG_COUNT];
    logic [COIL_COUNT-1:0] coil_q;
    logic [15:0]     rx_crc;
    logic [15:0]     tx_crc;

    // Query field decode
    wire logic [7:0]  q_addr   = rx_buf_q[POS_ADDR];
    wire logic [7:0]  q_fn     = rx_buf_q[POS_FN];
    wire logic [16:0] q_start  = {1'b0, rx_buf_q[POS_START_HI], rx_buf_q[POS_START_LO]};
    wire logic [16:0] q_qty    = {1'b0, rx_buf_q[POS_QTY_HI], rx_buf_q[POS_QTY_LO]};
    wire logic [16:0] q_bcnt   = {9'h000, rx_buf_q[POS_BCNT]};
    wire logic [16:0] q_len    = 17'(rx_len_q);
    wire logic [16:0] q_end    = q_start + q_qty;
    // RQ2 broadcast accepted
    wire logic        is_bcast = (q_addr == BROADCAST_ADDR);
    wire logic        for_us   = is_bcast || (q_addr == slave_addr_in);
    // RQ18 received CRC check
    wire logic        crc_ok   = (rx_crc == CRC_RESIDUE) && !overflow_q;
    wire logic        frame_ok = for_us && crc_ok;
    wire logic        qty_ok   = (q_qty != 17'h00000);

    // RQ1 coil write accepted
    wire logic ok_coils = frame_ok && (q_fn == FN_WRITE_COILS) && qty_ok
        && (q_end <= 17'(COIL_COUNT)) && (q_bcnt == ((q_qty + 17'h00007) >> 3))
        && (q_len == q_bcnt + 17'(POS_DATA + CRC_LEN));
    // RQ6 read query accepted
    // RQ16 broadcast reads dropped
    wire logic ok_read  = frame_ok && !is_bcast && (q_fn == FN_READ_REGS) && qty_ok
        && (q_end <= 17'(REG_COUNT)) && (q_len == 17'(FIXED_QUERY_LEN));
    // RQ9 single preset accepted
    wire logic ok_wr1   = frame_ok && (q_fn == FN_WRITE_REG)
        && (q_start < 17'(REG_COUNT)) && (q_len == 17'(FIXED_QUERY_LEN));
    // RQ12 multi preset accepted
    wire logic ok_wrn   = frame_ok && (q_fn == FN_WRITE_REGS) && qty_ok
        && (q_end <= 17'(REG_COUNT)) && (q_bcnt == (q_qty << 1))
        && (q_len == q_bcnt + 17'(POS_DATA + CRC_LEN));
    wire logic in_exec  = (state_q == ST_EXEC);
    wire logic do_exec  = in_exec && (ok_coils || ok_read || ok_wr1 || ok_wrn);
    wire logic do_reply = do_exec && !is_bcast;

    // Reply framing
    wire logic [7:0] body_len  = (q_fn == FN_READ_REGS) ?
                                 8'(READ_HDR_LEN + 2 * q_qty) : 8'(ECHO_LEN);
    wire logic [7:0] total_len = body_len + 8'(CRC_LEN);
    wire logic [7:0] rd_k      = tx_idx_q - 8'(READ_HDR_LEN);
    // RQ7 zero-based read address
    wire logic [RW-1:0] rd_reg = RW'(q_start + 17'(rd_k >> 1));
    wire logic [15:0] rd_word  = regs_q[rd_reg];
    // RQ8 high byte first
    wire logic [7:0] rd_byte   = rd_k[0] ? rd_word[7:0] : rd_word[15:8];
    // RQ17 byte count doubled
    wire logic [7:0] rd_body   = (tx_idx_q < 8'(POS_START_HI)) ? rx_buf_q[BW'(tx_idx_q)] :
                                 (tx_idx_q == 8'(POS_START_HI)) ? 8'(q_qty << 1) : rd_byte;
    // RQ5 coil write reply
    // RQ13 multi preset reply
    wire logic [7:0] echo_body = rx_buf_q[BW'(tx_idx_q)];
    wire logic [7:0] body_byte = (q_fn == FN_READ_REGS) ? rd_body : echo_body;
    wire logic       in_body   = (tx_idx_q < body_len);
    // RQ18 reply CRC, low byte first
    wire logic [7:0] resp_byte = in_body ? body_byte :
                                 (tx_idx_q == body_len) ? tx_crc[7:0] : tx_crc[15:8];
    wire logic       tx_hs     = (state_q == ST_SEND) && tx_ready_in;

    mrs_crc16 u_rx_crc (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .clear_in    (in_exec),
        .en_in       ((state_q == ST_RX) && rx_valid_in),
        .byte_in     (rx_byte_in),
        .crc_out     (rx_crc)
    );

    mrs_crc16 u_tx_crc (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .clear_in    (in_exec),
        .en_in       ((state_q == ST_LOAD) && in_body),
        .byte_in     (body_byte),
        .crc_out     (tx_crc)
    );

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_q    <= ST_RX;
            rx_len_q   <= '0;
            overflow_q <= 1'b0;
            tx_idx_q   <= 8'h00;
            tx_byte_q  <= 8'h00;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (rx_valid_in) begin
                        if (rx_len_q < LW'(MAX_FRAME)) begin
                            rx_len_q <= rx_len_q + LW'(1);
                        end else begin
                            overflow_q <= 1'b1;
                        end
                    end
                    if (rx_frame_end_in) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    rx_len_q   <= '0;
                    overflow_q <= 1'b0;
                    tx_idx_q   <= 8'h00;
                    // RQ11 reply after write
                    state_q    <= do_reply ? ST_LOAD : ST_RX;
                end
                ST_LOAD: begin
                    tx_byte_q <= resp_byte;
                    state_q   <= ST_SEND;
                end
                ST_SEND: begin
                    if (tx_ready_in) begin
                        tx_idx_q <= tx_idx_q + 8'h01;
                        state_q  <= (tx_idx_q + 8'h01 == total_len) ? ST_RX : ST_LOAD;
                    end
                end
                default: begin
                    state_q <= ST_RX;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if ((state_q == ST_RX) && rx_valid_in && (rx_len_q < LW'(MAX_FRAME))) begin
            rx_buf_q[BW'(rx_len_q)] <= rx_byte_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_reg
            wire logic [16:0]   off    = 17'(g) - q_start;
            wire logic [BW-1:0] pos_hi = BW'(17'(POS_DATA) + (off << 1));
            wire logic [BW-1:0] pos_lo = BW'(17'(POS_DATA + 1) + (off << 1));
            // RQ10 zero-based preset address
            wire logic wr1 = ok_wr1 && (q_start == 17'(g));
            // RQ14 high word lower
            wire logic wrn = ok_wrn && (17'(g) >= q_start) && (off < q_qty);
            wire logic [15:0] val = wr1 ? {rx_buf_q[POS_QTY_HI], rx_buf_q[POS_QTY_LO]} :
                                          {rx_buf_q[pos_hi], rx_buf_q[pos_lo]};
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    regs_q[g] <= REG_RESET;
                end else if (in_exec && (wr1 || wrn)) begin
                    regs_q[g] <= val;
                end
            end
            assign hold_regs_out[g*16 +: 16] = regs_q[g];
        end
        for (g = 0; g < COIL_COUNT; g++) begin : g_coil
            wire logic [16:0]   off  = 17'(g) - q_start;
            wire logic [BW-1:0] pos  = BW'(17'(POS_DATA) + (off >> 3));
            // RQ3 zero-based coil address
            wire logic          hit  = ok_coils && (17'(g) >= q_start) && (off < q_qty);
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    coil_q[g] <= 1'b0;
                end else if (in_exec && hit) begin
                    coil_q[g] <= rx_buf_q[pos][off[2:0]];
                end
            end
        end
    endgenerate

    // RQ4 speed reference coils
    assign speed_ref_out = {coil_q[SPEED_REF_ADDR +: 8], coil_q[SPEED_REF_ADDR + 8 +: 8]};
    assign coils_out     = coil_q;
    assign rx_idle_out   = (state_q == ST_RX);
    assign tx_byte_out   = tx_byte_q;
    assign tx_valid_out  = (state_q == ST_SEND);
    assign tx_last_out   = (state_q == ST_SEND) && (tx_idx_q + 8'h01 == total_len);
endmodule
`default_nettype wire

// File: core/mrs_pkg.sv
// Shared constants for the serial slave function handler
`default_nettype none
package mrs_pkg;
    localparam logic [7:0]  FN_WRITE_COILS  = 8'h0f;
    localparam logic [7:0]  FN_READ_REGS    = 8'h03;
    localparam logic [7:0]  FN_WRITE_REG    = 8'h06;
    localparam logic [7:0]  FN_WRITE_REGS   = 8'h10;
    localparam logic [7:0]  BROADCAST_ADDR  = 8'h00;
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE     = 16'h0000;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    localparam int          POS_ADDR        = 0;
    localparam int          POS_FN          = 1;
    localparam int          POS_START_HI    = 2;
    localparam int          POS_START_LO    = 3;
    localparam int          POS_QTY_HI      = 4;
    localparam int          POS_QTY_LO      = 5;
    localparam int          POS_BCNT        = 6;
    localparam int          POS_DATA        = 7;
    localparam int          FIXED_QUERY_LEN = 8;
    localparam int          CRC_LEN         = 2;
    localparam int          ECHO_LEN        = 6;
    localparam int          READ_HDR_LEN    = 3;
    localparam int          COIL_NUM_OFFSET = 1;
    localparam int          SPEED_REF_COIL  = 17;
    localparam int          SPEED_REF_ADDR  = SPEED_REF_COIL - COIL_NUM_OFFSET;
    typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_LOAD, ST_SEND} mrs_state_type;
endpackage
`default_nettype wire

// File: core/mrs_crc16.sv
// Running CRC-16 over a byte stream, reflected polynomial
`default_nettype none
module mrs_crc16
    import mrs_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clear_in,
    input  wire logic        en_in,
    input  wire logic [7:0]  byte_in,
    output logic      [15:0] crc_out
);
    logic [15:0] crc_q;
    logic [15:0] crc_d;

    always_comb begin
        crc_d = crc_q ^ {8'h00, byte_in};
        for (int b = 0; b < 8; b++) begin
            crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || clear_in) begin
            crc_q <= CRC_INIT;
        end else if (en_in) begin
            crc_q <= crc_d;
        end
    end

    assign crc_out = crc_q;
endmodule
`default_nettype wire

// File: tb/mrs_monitor.sv
// Port checks for the slave function handler
`default_nettype none
module mrs_monitor #(
    parameter int REG_COUNT  = 16,
    parameter int COIL_COUNT = 64
) (
    input wire logic                    core_clk_in,
    input wire logic                    sys_rst_in,
    input wire logic                    rx_frame_end_in,
    input wire logic                    rx_idle_out,
    input wire logic [7:0]              tx_byte_out,
    input wire logic                    tx_valid_out,
    input wire logic                    tx_last_out,
    input wire logic                    tx_ready_in,
    input wire logic [COIL_COUNT-1:0]   coils_out,
    input wire logic [REG_COUNT*16-1:0] hold_regs_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_reset_clears: assert property (disable iff (1'b0) sys_rst_in |=> coils_out == '0
        && hold_regs_out == '0 && !tx_valid_out && rx_idle_out) else $error("reset state");
    a_byte_held: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_byte_out)) else $error("reply byte dropped");
    a_load_gap: assert property (tx_valid_out && tx_ready_in |=> !tx_valid_out)
        else $error("no gap after byte");
    a_last_valid: assert property (tx_last_out && tx_ready_in |=> rx_idle_out)
        else $error("no return to receive after last byte");
    a_tx_not_idle: assert property (rx_idle_out |=> !tx_valid_out)
        else $error("reply started straight from receive");
    a_no_early_reply: assert property (rx_frame_end_in && rx_idle_out |=>
        !tx_valid_out [*2]) else $error("reply before write");
    a_regs_after_end: assert property ($changed(hold_regs_out) |->
        $past(rx_frame_end_in, 2) || $past(rx_frame_end_in, 3)) else $error("stray reg write");
    a_coils_after_end: assert property ($changed(coils_out) |->
        $past(rx_frame_end_in, 2) || $past(rx_frame_end_in, 3)) else $error("stray coil write");
    c_stall: cover property (tx_valid_out && !tx_ready_in);
    c_last: cover property (tx_last_out && tx_ready_in);
    c_coils: cover property ($changed(coils_out));
endmodule
`default_nettype wire

// File: tb/mrs_master_model.sv
// Serial master model: sends framed queries, collects replies
`default_nettype none
module mrs_master_model (
    input  wire logic       clk_in,
    input  wire logic       idle_in,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_valid_in,
    input  wire logic       tx_last_in,
    output logic      [7:0] rx_byte_out,
    output logic            rx_valid_out,
    output logic            rx_end_out,
    output logic            tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       slow = 1'b0;
    logic [8:0] got[$];
    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
        rx_end_out = 1'b0;
        tx_ready_out = 1'b1;
    end
    function automatic logic [15:0] crc(input logic [127:0] f, input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = n - 1; i >= 0; i--) begin
            c = c ^ {8'h00, f[8*i+:8]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send(input logic [127:0] f, input int n, input logic bad);
        logic [15:0] c;
        c = crc(f, n) ^ {15'h0000, bad};
        got.delete();
        for (int k = 0; k < 400 && !idle_in; k++) @(negedge clk_in);
        @(posedge clk_in);
        for (int i = n + 1; i >= 0; i--) begin
            rx_byte_out <= i > 1 ? f[8*(i-2)+:8] : (i == 1 ? c[7:0] : c[15:8]);
            rx_valid_out <= 1'b1;
            rx_end_out <= i == 0;
            @(posedge clk_in);
        end
        rx_valid_out <= 1'b0;
        rx_end_out <= 1'b0;
        rx_byte_out <= ~c[15:8];
    endtask
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) got.push_back({tx_last_in, tx_byte_in});
        tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the slave function handler
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mrs_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   rxb;
    logic [7:0]   txb;
    logic         rxv;
    logic         rxe;
    logic         idle;
    logic         txv;
    logic         txl;
    logic         txr;
    logic [63:0]  coils;
    logic [15:0]  sref;
    logic [255:0] regs;
    int           num_errors = 0;
    int           total_checks = 0;
    always #50 clk = ~clk;
    mrs_slave_functions u_dut (.core_clk_in(clk), .sys_rst_in(rst), .slave_addr_in(8'h01),
        .rx_byte_in(rxb), .rx_valid_in(rxv), .rx_frame_end_in(rxe), .rx_idle_out(idle),
        .tx_byte_out(txb), .tx_valid_out(txv), .tx_last_out(txl), .tx_ready_in(txr),
        .coils_out(coils), .speed_ref_out(sref), .hold_regs_out(regs));
    mrs_master_model u_m (.clk_in(clk), .idle_in(idle), .tx_byte_in(txb), .tx_valid_in(txv),
        .tx_last_in(txl), .rx_byte_out(rxb), .rx_valid_out(rxv), .rx_end_out(rxe),
        .tx_ready_out(txr));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic run(input logic [127:0] q, input int nq, input logic [127:0] e,
                       input int ne, input logic bad);
        logic [15:0] c;
        logic [7:0]  b;
        c = u_m.crc(e, ne);
        u_m.send(q, nq, bad);
        repeat (3) @(negedge clk);
        for (int k = 0; k < 300 && !(idle && u_m.got.size() == (ne ? ne + 2 : 0)); k++)
            @(negedge clk);
        chk(idle, 1'b1);
        chk(u_m.got.size(), ne ? ne + 2 : 0);
        for (int i = 0; i < ne + 2 && ne > 0; i++) begin
            b = i < ne ? e[8*(ne-1-i)+:8] : (i == ne ? c[7:0] : c[15:8]);
            chk(u_m.got[i], {i == ne + 1, b});
        end
    endtask
    task automatic t_coils();
        run(72'h010f0010001002_2000, 9, 48'h010f00100010, 6, 1'b0);
        chk(sref, 16'h2000);
        chk(coils[31:0], 32'h0020_0000);
    endtask
    task automatic t_bcast();
        run(72'h000f0010001002_0180, 9, 0, 0, 1'b0);
        chk(sref, 16'h0180);
        chk(coils[31:0], 32'h8001_0000);
    endtask
    task automatic t_single();
        u_m.slow = 1'b1;
        run(48'h010600010003, 6, 48'h010600010003, 6, 1'b0);
        u_m.slow = 1'b0;
        chk(regs[31:0], 32'h0003_0000);
    endtask
    task automatic t_multi();
        run(88'h01100004000204_000102e2, 11, 48'h011000040002, 6, 1'b0);
        chk(regs[95:64], 32'h02e2_0001);
    endtask
    task automatic t_read();
        run(48'h010300040003, 6, 72'h010306_000102e2_0000, 9, 1'b0);
    endtask
    task automatic t_drop();
        run(48'h01060002ffff, 6, 0, 0, 1'b1);
        chk(regs[47:32], 16'h0000);
        run(48'h000300000001, 6, 0, 0, 1'b0);
        run(48'h02060002ffff, 6, 0, 0, 1'b0);
        chk(regs[47:32], 16'h0000);
        run(48'h0103000f0002, 6, 0, 0, 1'b0);
        run(48'h000600071234, 6, 0, 0, 1'b0);
        chk(regs[127:112], 16'h1234);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_coils();
        t_bcast();
        t_single();
        t_multi();
        t_read();
        t_drop();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
bind mrs_slave_functions mrs_monitor #(.REG_COUNT(REG_COUNT), .COIL_COUNT(COIL_COUNT)) u_mon (.*);
`default_nettype wire
